// File: hw/osp_sequencer.sv
/*
 * osp_sequencer: command interpreter and run engine of the output
 * sequence programmer; edit buffer, commit copy, settings, runner.
 * assumes: a same-clock register master, one strobe per cycle.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - run-state read gives RUN, STOP, PAUSE or EDIT
// - edit select enters editing of that sequence
// - edit select accepts sequence 1 to 16 only
// - edit query returns sequence under edit
// - step select 1 to 500 targets later edits
// - step voltage stored, up to 105 percent
// - step current stored, up to 105 percent
// - step power stored, up to 102 percent
// - step duration 0.001 to 99999.999 s stored
// - commit copies edits over saved sequence, exits
// - commit status PROCESSING until done, then DONE
// - commit forces loop count 0, end step 2
// - end step 1 to 500 stored and readable
// - loop count 1 to 999999 stored, readable
// - execution order list, 16 positions, readable
// - live position, zeros when nothing active
// - run after stop restarts at first step
// - run after pause during step hold resumes at next step, but pause in the last step of the last loop stops; pause in fetch or load resumes same step
module osp_sequencer
   import osp_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire osp_req_type req_i,
   output var logic [31:0] rdata_o,
   output var osp_step_type setpoint_o,
   output logic out_on_o
);

   localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);

   osp_step_type edit_mem [STEPS];
   logic [19:0] loopn_q [NSEQ];
   logic [8:0] end_q [NSEQ];
   logic [4:0] list_q [NSEQ];

   osp_ed_type ed_q;
   osp_run_type rs_q;
   logic [3:0] sel_seq_q;
   logic [8:0] step_sel_q;
   logic [8:0] cidx_q;
   logic err_q;
   logic [3:0] run_seq_q;
   logic [8:0] run_step_q;
   logic [19:0] run_loop_q;
   logic [TICK_W-1:0] pre_q;
   logic [26:0] ms_left_q;

   logic [31:0] arg;
   logic mapped;
   logic ok;
   logic acc;
   logic editing;
   logic run_cmd;
   logic stop_cmd;
   logic pause_cmd;
   logic copy_we;
   logic tick;
   logic last_step;
   logic last_loop;
   logic [4:0] list_pos;
   osp_step_type st_rdata;

   assign arg = req_i.wdata;
   assign editing = (ed_q == ED_EDIT);
   assign list_pos = 5'(arg[LIST_POS_LSB +: 5] - 5'h01);

   // argument checking per command
   always_comb begin
      mapped = 1'b1;
      ok = 1'b0;
      case (req_i.addr)
         OFS_RUN: ok = (arg == CMD_RUN && ed_q == ED_IDLE) ||
                       arg == CMD_STOP || arg == CMD_PAUSE;
         OFS_EDIT: ok = ed_q != ED_COPY && arg >= SEQ_MIN &&
                        arg <= NSEQ;
         OFS_STEP: ok = editing && arg >= STEP_MIN &&
                        arg <= STEPS;
         OFS_VOLT: ok = editing && arg <= VOLT_MAX;
         OFS_CURR: ok = editing && arg <= CURR_MAX;
         OFS_PWR: ok = editing && arg <= PWR_MAX;
         OFS_DUR: ok = editing && arg >= DUR_MIN &&
                       arg <= DUR_MAX;
         OFS_COMMIT: ok = editing;
         OFS_END: ok = arg >= STEP_MIN && arg <= STEPS;
         OFS_LOOP: ok = arg >= 1 && arg <= LOOP_MAX;
         OFS_LIST: ok = arg[LIST_POS_LSB +: 16] >= POS_MIN &&
                        arg[LIST_POS_LSB +: 16] <= NSEQ &&
                        arg[15:0] <= LIST_SEQ_MAX;
         OFS_ERR: ok = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   assign acc = ce_i && req_i.wr && ok;
   assign run_cmd = acc && req_i.addr == OFS_RUN && arg == CMD_RUN;
   assign stop_cmd = acc && req_i.addr == OFS_RUN && arg == CMD_STOP;
   assign pause_cmd = acc && req_i.addr == OFS_RUN && arg == CMD_PAUSE;
   assign copy_we = (ed_q == ED_COPY);

   // sticky reject flag; a new reject beats a clear in the same cycle
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         err_q <= 1'b0;
      end else if (ce_i) begin
         if (req_i.wr && mapped && !ok) begin
            err_q <= 1'b1;
         end else if (acc && req_i.addr == OFS_ERR && arg[0]) begin
            err_q <= 1'b0;
         end
      end
   end

   // editor: select, edit, commit copy
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ed_q <= ED_IDLE;
         sel_seq_q <= '0;
         step_sel_q <= '0;
         cidx_q <= '0;
      end else if (ce_i) begin
         unique case (ed_q)
            ED_IDLE, ED_EDIT: begin
               if (acc && req_i.addr == OFS_EDIT) begin
                  sel_seq_q <= 4'(arg - 32'h1);
                  ed_q <= ED_EDIT;
               end else if (acc && req_i.addr == OFS_STEP) begin
                  step_sel_q <= 9'(arg - 32'h1);
               end else if (acc && req_i.addr == OFS_COMMIT) begin
                  cidx_q <= '0;
                  ed_q <= ED_COPY;
               end
            end
            ED_COPY: begin
               if (cidx_q == 9'(STEPS - 1)) begin
                  ed_q <= ED_IDLE;
               end else begin
                  cidx_q <= cidx_q + 9'h001;
               end
            end
         endcase
      end
   end

   // edit buffer: one entry per step of the open sequence
   always_ff @(posedge mclk_i) begin
      if (acc) begin
         case (req_i.addr)
            OFS_VOLT: edit_mem[step_sel_q].volt <= arg[15:0];
            OFS_CURR: edit_mem[step_sel_q].curr <= arg[15:0];
            OFS_PWR: edit_mem[step_sel_q].pwr <= arg[15:0];
            OFS_DUR: edit_mem[step_sel_q].dur <= arg[26:0];
            default: ;
         endcase
      end
   end

   // per-sequence settings and the order list
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < NSEQ; i++) begin
            loopn_q[i] <= LOOP_RST;
            end_q[i] <= END_RST;
            list_q[i] <= '0;
         end
      end else if (ce_i) begin
         if (copy_we && cidx_q == 9'(STEPS - 1)) begin
            loopn_q[sel_seq_q] <= COMMIT_LOOP;
            end_q[sel_seq_q] <= COMMIT_END;
         end else if (acc && req_i.addr == OFS_END) begin
            end_q[sel_seq_q] <= arg[8:0];
         end else if (acc && req_i.addr == OFS_LOOP) begin
            loopn_q[sel_seq_q] <= arg[19:0];
         end
         if (acc && req_i.addr == OFS_LIST) begin
            list_q[list_pos[3:0]] <= arg[4:0];
         end
      end
   end

   // saved steps; copy writes while the runner may only read
   osp_step_store u_store (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .we_i(copy_we),
      .wseq_i(sel_seq_q),
      .wstep_i(cidx_q),
      .wdata_i(edit_mem[cidx_q]),
      .rseq_i(run_seq_q),
      .rstep_i(run_step_q),
      .rdata_o(st_rdata)
   );

   // runner: step timing, end step, loop count
   assign tick = (pre_q == TICK_W'(TICK_CYCLES - 1));
   assign last_step = (10'(run_step_q) + 10'h001) >= 10'(end_q[run_seq_q]);
   assign last_loop = run_loop_q >= loopn_q[run_seq_q];

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rs_q <= RS_STOP;
         run_seq_q <= '0;
         run_step_q <= '0;
         run_loop_q <= '0;
         pre_q <= '0;
         ms_left_q <= '0;
         setpoint_o <= '0;
      end else if (ce_i) begin
         if (stop_cmd) begin
            rs_q <= RS_STOP;
            run_step_q <= '0;
            setpoint_o <= '0;
         end else begin
            unique case (rs_q)
               RS_STOP: begin
                  if (run_cmd) begin
                     run_seq_q <= sel_seq_q;
                     run_step_q <= '0;
                     run_loop_q <= LOOP_RST;
                     rs_q <= RS_FETCH;
                  end
               end
               RS_PAUSE: begin
                  if (run_cmd) begin
                     rs_q <= RS_FETCH;
                  end
               end
               RS_FETCH: begin
                  rs_q <= pause_cmd ? RS_PAUSE : RS_LOAD;
               end
               RS_LOAD: begin
                  setpoint_o <= st_rdata;
                  ms_left_q <= st_rdata.dur;
                  pre_q <= '0;
                  rs_q <= pause_cmd ? RS_PAUSE : RS_HOLD;
               end
               RS_HOLD: begin
                  pre_q <= tick ? '0 : pre_q + TICK_W'(1);
                  if (tick && ms_left_q != '0) begin
                     ms_left_q <= ms_left_q - 27'h0000001;
                  end
                  // pause ends the step like a timeout: next step on resume, or stop after the last step of the last loop
                  if (pause_cmd || (tick && ms_left_q <= 27'h0000001)) begin
                     if (last_step && last_loop) begin
                        rs_q <= RS_STOP;
                        run_step_q <= '0;
                        setpoint_o <= '0;
                     end else begin
                        rs_q <= pause_cmd ? RS_PAUSE : RS_FETCH;
                        if (last_step) begin
                           run_step_q <= '0;
                           run_loop_q <= run_loop_q + 20'h00001;
                        end else begin
                           run_step_q <= run_step_q + 9'h001;
                        end
                     end
                  end
               end
               default: rs_q <= RS_STOP;
            endcase
         end
      end
   end

   assign out_on_o = (rs_q == RS_HOLD);

   // read data, one cycle after the read strobe
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= '0;
      end else if (ce_i) begin
         rdata_o <= '0;
         if (req_i.rd) begin
            case (req_i.addr)
               OFS_RUN: begin
                  if (ed_q != ED_IDLE) begin
                     rdata_o <= 32'(ANS_EDIT);
                  end else if (rs_q == RS_STOP || run_seq_q != sel_seq_q) begin
                     rdata_o <= 32'(ANS_STOP);
                  end else if (rs_q == RS_PAUSE) begin
                     rdata_o <= 32'(ANS_PAUSE);
                  end else begin
                     rdata_o <= 32'(ANS_RUN);
                  end
               end
               OFS_EDIT: rdata_o <= 32'(sel_seq_q) + 32'h1;
               OFS_STEP: rdata_o <= 32'(step_sel_q) + 32'h1;
               // readback targets the step already selected by the host
               OFS_VOLT: rdata_o <= 32'(edit_mem[step_sel_q].volt);
               OFS_CURR: rdata_o <= 32'(edit_mem[step_sel_q].curr);
               OFS_PWR: rdata_o <= 32'(edit_mem[step_sel_q].pwr);
               OFS_DUR: rdata_o <= 32'(edit_mem[step_sel_q].dur);
               OFS_COMMIT: rdata_o <= (ed_q == ED_IDLE) ?
                  32'(ANS_DONE) : 32'(ANS_PROCESSING);
               OFS_END: rdata_o <= 32'(end_q[sel_seq_q]);
               OFS_LOOP: rdata_o <= 32'(loopn_q[sel_seq_q]);
               OFS_NOW_POS: begin
                  if (rs_q != RS_STOP) begin
                     rdata_o <= (32'(run_seq_q) + 32'h1) << NOW_SEQ_LSB |
                                (32'(run_step_q) + 32'h1);
                  end
               end
               OFS_NOW_LOOP: begin
                  if (rs_q != RS_STOP) begin
                     rdata_o <= 32'(run_loop_q);
                  end
               end
               OFS_ERR: rdata_o <= 32'(err_q);
               default: begin
                  if (req_i.addr[7:6] == LIST_RD_TAG) begin
                     rdata_o <= 32'(list_q[req_i.addr[5:2]]);
                  end
               end
            endcase
         end
      end
   end

endmodule : osp_sequencer

`default_nettype wire

// File: include/osp_pkg.sv
/*
 * osp_pkg: shared constants, types and the register map of the
 * output sequence programmer.
 * assumes: one 10 MHz clock; values are in units of 0.01 % of rating.
 */
package osp_pkg;

   // clock and step-time base
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned TIME_UNIT_NS = 1_000_000;  // durations in 1 ms
   localparam int unsigned TICK_CYCLES_DEF = TIME_UNIT_NS / CLK_PERIOD_NS;

   // sizes
   localparam int unsigned NSEQ = 16;
   localparam int unsigned STEPS = 500;
   localparam int unsigned STORE_WORDS = NSEQ * STEPS;

   // argument limits; rated value is RATED_UNITS
   localparam int unsigned RATED_UNITS = 10_000;
   localparam int unsigned VOLT_MAX = RATED_UNITS * 105 / 100;
   localparam int unsigned CURR_MAX = RATED_UNITS * 105 / 100;
   localparam int unsigned PWR_MAX = RATED_UNITS * 102 / 100;
   localparam int unsigned DUR_MIN = 1;
   localparam int unsigned DUR_MAX = 99_999_999;
   localparam int unsigned LOOP_MAX = 999_999;
   localparam int unsigned LIST_SEQ_MAX = 16;
   localparam int unsigned SEQ_MIN = 1;
   localparam int unsigned STEP_MIN = 1;
   localparam int unsigned POS_MIN = 1;

   // values forced on commit
   localparam logic [19:0] COMMIT_LOOP = 20'h00000;
   localparam logic [8:0] COMMIT_END = 9'h002;

   // reset values
   localparam logic [19:0] LOOP_RST = 20'h00001;
   localparam logic [8:0] END_RST = 9'h002;

   // register byte offsets
   localparam logic [7:0] OFS_RUN = 8'h00;
   localparam logic [7:0] OFS_EDIT = 8'h04;
   localparam logic [7:0] OFS_STEP = 8'h08;
   localparam logic [7:0] OFS_VOLT = 8'h0c;
   localparam logic [7:0] OFS_CURR = 8'h10;
   localparam logic [7:0] OFS_PWR = 8'h14;
   localparam logic [7:0] OFS_DUR = 8'h18;
   localparam logic [7:0] OFS_COMMIT = 8'h1c;
   localparam logic [7:0] OFS_END = 8'h20;
   localparam logic [7:0] OFS_LOOP = 8'h24;
   localparam logic [7:0] OFS_LIST = 8'h28;
   localparam logic [7:0] OFS_NOW_POS = 8'h2c;
   localparam logic [7:0] OFS_NOW_LOOP = 8'h30;
   localparam logic [7:0] OFS_ERR = 8'h34;
   localparam logic [1:0] LIST_RD_TAG = 2'h1;  // 0x40..0x7c: list entries

   // field positions
   localparam int unsigned LIST_POS_LSB = 16;
   localparam int unsigned NOW_SEQ_LSB = 16;

   // run control codes written to OFS_RUN
   localparam logic [31:0] CMD_RUN = 32'h00000001;
   localparam logic [31:0] CMD_STOP = 32'h00000002;
   localparam logic [31:0] CMD_PAUSE = 32'h00000003;

   // answer codes
   localparam logic [1:0] ANS_RUN = 2'h0;
   localparam logic [1:0] ANS_STOP = 2'h1;
   localparam logic [1:0] ANS_PAUSE = 2'h2;
   localparam logic [1:0] ANS_EDIT = 2'h3;
   localparam logic ANS_DONE = 1'b0;
   localparam logic ANS_PROCESSING = 1'b1;

   typedef struct packed {
      logic [26:0] dur;
      logic [15:0] pwr;
      logic [15:0] curr;
      logic [15:0] volt;
   } osp_step_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } osp_req_type;

   typedef enum logic [1:0] {ED_IDLE, ED_EDIT, ED_COPY} osp_ed_type;
   typedef enum logic [2:0] {
      RS_STOP, RS_FETCH, RS_LOAD, RS_HOLD, RS_PAUSE
   } osp_run_type;

endpackage : osp_pkg

// File: hw/osp_step_store.sv
/*
 * osp_step_store: saved steps of all sequences, one write port and one
 * registered read port.
 * assumes: caller never reads and writes the same word in one cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module osp_step_store
   import osp_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic we_i,
   input wire logic [3:0] wseq_i,
   input wire logic [8:0] wstep_i,
   input wire osp_step_type wdata_i,
   input wire logic [3:0] rseq_i,
   input wire logic [8:0] rstep_i,
   output var osp_step_type rdata_o
);

   osp_step_type mem [STORE_WORDS];
   logic [12:0] widx;
   logic [12:0] ridx;

   assign widx = 13'(int'(wseq_i) * STEPS + int'(wstep_i));
   assign ridx = 13'(int'(rseq_i) * STEPS + int'(rstep_i));

   always_ff @(posedge mclk_i) begin
      if (ce_i && we_i) begin
         mem[widx] <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= '0;
      end else if (ce_i) begin
         rdata_o <= mem[ridx];
      end
   end

endmodule : osp_step_store

`default_nettype wire

// File: testbench/osp_sequencer_assertions.sv
/* osp_seq_chk: port assertions for osp_sequencer.
   assumes: bound onto the top module, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module osp_seq_chk
   import osp_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire osp_req_type req_i,
   input wire logic [31:0] rdata_o,
   input wire osp_step_type setpoint_o,
   input wire logic out_on_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   logic ed_q;
   logic [4:0] eseq_q;
   logic [9:0] age_q;
   logic [1:0] runw_q;
   logic [26:0] hi_q;
   wire wv = ce_i && req_i.wr;
   wire rv = ce_i && req_i.rd;
   // copy lasts 500 enabled cycles; edit select is taken again after it
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ed_q <= 1'b0;
         eseq_q <= 5'd1;
         age_q <= 10'd1000;
      end else if (wv && req_i.addr == OFS_COMMIT && ed_q) begin
         ed_q <= 1'b0;
         age_q <= 10'd0;
      end else if (ce_i) begin
         if (wv && req_i.addr == OFS_EDIT && age_q >= 10'd500 &&
             req_i.wdata inside {[1:16]}) begin
            ed_q <= 1'b1;
            eseq_q <= req_i.wdata[4:0];
         end
         if (age_q < 10'd1000)
            age_q <= age_q + 10'd1;
      end
   end
   // stop or pause may cut a step short
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         runw_q <= 2'b00;
      else
         runw_q <= {runw_q[0], wv && req_i.addr == OFS_RUN};
   end
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         hi_q <= 27'h0;
      else if (out_on_o)
         hi_q <= hi_q + 27'h1;
      else
         hi_q <= 27'h0;
   end
   chk_run_edit: assert property (rv && req_i.addr == OFS_RUN && ed_q
      |=> rdata_o == {30'h0, ANS_EDIT}) else $error("run state not edit");
   chk_run_code: assert property (rv && req_i.addr == OFS_RUN
      |=> rdata_o[31:2] == 30'h0) else $error("run state code too wide");
   chk_edit_range: assert property (rv && req_i.addr == OFS_EDIT
      |=> rdata_o == 32'(eseq_q)) else $error("edit number not selected one");
   chk_busy_answer: assert property (rv && req_i.addr == OFS_COMMIT &&
      (ed_q || age_q < 10'd500) |=> rdata_o == {31'h0, ANS_PROCESSING})
      else $error("commit status not processing");
   chk_done_answer: assert property (rv && req_i.addr == OFS_COMMIT &&
      !ed_q && age_q >= 10'd500 |=> rdata_o == {31'h0, ANS_DONE})
      else $error("commit status not done");
   chk_reject_flag: assert property ((wv && req_i.addr == OFS_VOLT &&
      req_i.wdata > VOLT_MAX) ##1 (rv && req_i.addr == OFS_ERR)
      |=> rdata_o[0]) else $error("rejected write left no flag");
   chk_hold_stable: assert property (out_on_o && $past(out_on_o)
      |-> $stable(setpoint_o)) else $error("setpoint moved within step");
   chk_stop_clears: assert property (wv && req_i.addr == OFS_RUN &&
      req_i.wdata == CMD_STOP |-> ##[1:3] (setpoint_o == '0 && !out_on_o))
      else $error("stop left output active");
   chk_step_length: assert property ($fell(out_on_o) && runw_q == 2'b00
      |-> hi_q >= TICK_CYCLES) else $error("step ended too early");
endmodule : osp_seq_chk
`default_nettype wire

// File: testbench/osp_host_model.sv
/* osp_host_model: remote host issuing register commands.
   assumes: caller keeps step-then-values order. */
`timescale 1ns/1ps
`default_nettype none
module osp_host_model
   import osp_pkg::*;
(
   input wire logic mclk_i,
   output var osp_req_type req_o
);
   initial req_o = '0;
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      req_o <= '{a, d, 1'b1, 1'b0};
   endtask : wr
   // unused data lines show inverted history, never a stale copy
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      req_o <= '{a, ~req_o.wdata, 1'b0, 1'b1};
   endtask : rd
   task automatic idle(input int n);
      @(posedge mclk_i);
      req_o <= '{~req_o.addr, ~req_o.wdata, 1'b0, 1'b0};
      repeat (n) @(posedge mclk_i);
   endtask : idle
endmodule : osp_host_model
`default_nettype wire

// File: testbench/osp_sequencer_test.sv
/* osp_sequencer_test: self-checking bench for osp_sequencer.
   assumes: host model and checker compiled before this file. */
`timescale 1ns/1ps
`default_nettype none
module osp_sequencer_test
   import osp_pkg::*;
;
   localparam int unsigned TK = 4;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic ce_i = 1'b1;
   osp_req_type req_i;
   logic [31:0] rdata_o;
   osp_step_type setpoint_o;
   logic out_on_o;
   logic [31:0] exp_q[$];
   logic rd_q = 1'b0;
   int miscompares = 0;
   int total_checks = 0;
   osp_step_type st[3];
   logic [8:0] sn[3] = '{9'd1, 9'd2, 9'd500};
   logic [31:0] pos;
   initial forever #50 mclk_i = ~mclk_i;
   osp_host_model u_host (.mclk_i(mclk_i), .req_o(req_i));
   osp_sequencer #(.TICK_CYCLES(TK)) DUT (.mclk_i(mclk_i),
      .rst_b_i(rst_b_i), .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o),
      .setpoint_o(setpoint_o), .out_on_o(out_on_o));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   task automatic cmp(input logic [74:0] e, input logic [74:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t exp %h got %h", $time, e, g);
      end
   endtask : cmp
   // answer stands only in the cycle after the read strobe
   always @(posedge mclk_i) begin
      if (rd_q)
         cmp(75'(exp_q.pop_front()), 75'(rdata_o));
      rd_q <= req_i.rd && ce_i;
   end
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      u_host.rd(a);
   endtask : chk
   task automatic sp(input osp_step_type e);
      cmp(75'(e), 75'(setpoint_o));
   endtask : sp
   task automatic wait_on(input logic v);
      int n;
      n = 0;
      u_host.idle(0);
      while (out_on_o !== v) begin
         @(posedge mclk_i);
         n++;
         if (n > 400) begin
            miscompares++;
            print_verdict();
         end
      end
   endtask : wait_on
   initial begin
      void'($urandom(32'h488cc89f));
      repeat (6) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      chk(OFS_RUN, 32'(ANS_STOP));
      chk(OFS_EDIT, 32'd1);
      chk(OFS_STEP, 32'd1);
      chk(OFS_LOOP, 32'(LOOP_RST));
      chk(OFS_END, 32'(END_RST));
      chk(OFS_NOW_POS, 32'h0);
      chk(OFS_COMMIT, 32'(ANS_DONE));
      chk(8'h40, 32'h0);
      chk(8'h38, 32'h0);
      $display("test reset values done");
      u_host.wr(OFS_EDIT, 32'd17);
      chk(OFS_ERR, 32'h1);
      u_host.wr(OFS_ERR, 32'h1);
      u_host.wr(OFS_EDIT, 32'd16);
      chk(OFS_EDIT, 32'd16);
      chk(OFS_RUN, 32'(ANS_EDIT));
      chk(OFS_ERR, 32'h0);
      u_host.wr(OFS_RUN, CMD_RUN);
      chk(OFS_ERR, 32'h1);
      u_host.wr(OFS_ERR, 32'h1);
      $display("test edit select done");
      for (int i = 0; i < 3; i++) begin
         st[i].volt = (i == 2) ? 16'(VOLT_MAX) : 16'($urandom_range(VOLT_MAX));
         st[i].curr = (i == 2) ? 16'(CURR_MAX) : 16'($urandom_range(CURR_MAX));
         st[i].pwr = (i == 2) ? 16'(PWR_MAX) : 16'($urandom_range(PWR_MAX));
         st[i].dur = (i == 2) ? 27'(DUR_MAX) : 27'(3 - i);
         u_host.wr(OFS_STEP, 32'(sn[i]));
         u_host.wr(OFS_VOLT, 32'(st[i].volt));
         u_host.wr(OFS_CURR, 32'(st[i].curr));
         u_host.wr(OFS_PWR, 32'(st[i].pwr));
         u_host.wr(OFS_DUR, 32'(st[i].dur));
      end
      for (int i = 0; i < 3; i++) begin
         u_host.wr(OFS_STEP, 32'(sn[i]));
         chk(OFS_STEP, 32'(sn[i]));
         chk(OFS_VOLT, 32'(st[i].volt));
         chk(OFS_CURR, 32'(st[i].curr));
         chk(OFS_PWR, 32'(st[i].pwr));
         chk(OFS_DUR, 32'(st[i].dur));
      end
      u_host.wr(OFS_VOLT, VOLT_MAX + 1);
      chk(OFS_ERR, 32'h1);
      u_host.wr(OFS_DUR, 32'h0);
      u_host.wr(OFS_STEP, 32'd501);
      u_host.wr(OFS_STEP, 32'd0);
      chk(OFS_STEP, 32'd500);
      chk(OFS_VOLT, 32'(VOLT_MAX));
      chk(OFS_DUR, 32'(DUR_MAX));
      $display("test step edit done");
      u_host.wr(OFS_LOOP, 32'd5);
      u_host.wr(OFS_END, 32'd6);
      u_host.wr(OFS_COMMIT, 32'h0);
      chk(OFS_COMMIT, 32'(ANS_PROCESSING));
      chk(OFS_RUN, 32'(ANS_EDIT));
      u_host.idle(600);
      chk(OFS_COMMIT, 32'(ANS_DONE));
      chk(OFS_LOOP, 32'h0);
      chk(OFS_END, 32'd2);
      chk(OFS_RUN, 32'(ANS_STOP));
      $display("test commit done");
      pos = 32'd16 << NOW_SEQ_LSB;
      u_host.wr(OFS_RUN, CMD_RUN);
      wait_on(1'b1);
      sp(st[0]);
      chk(OFS_RUN, 32'(ANS_RUN));
      chk(OFS_NOW_POS, pos | 32'd1);
      u_host.wr(OFS_RUN, CMD_PAUSE);
      chk(OFS_RUN, 32'(ANS_PAUSE));
      chk(OFS_NOW_POS, pos | 32'd2);
      chk(OFS_NOW_LOOP, 32'd1);
      u_host.wr(OFS_RUN, CMD_RUN);
      wait_on(1'b1);
      sp(st[1]);
      u_host.wr(OFS_RUN, CMD_STOP);
      u_host.idle(2);
      chk(OFS_NOW_POS, 32'h0);
      chk(OFS_NOW_LOOP, 32'h0);
      chk(OFS_RUN, 32'(ANS_STOP));
      u_host.wr(OFS_RUN, CMD_RUN);
      wait_on(1'b1);
      sp(st[0]);
      wait_on(1'b0);
      wait_on(1'b1);
      sp(st[1]);
      wait_on(1'b0);
      u_host.idle(4);
      chk(OFS_NOW_POS, 32'h0);
      chk(OFS_RUN, 32'(ANS_STOP));
      $display("test run control done");
      u_host.wr(OFS_END, 32'd500);
      u_host.wr(OFS_END, 32'd501);
      chk(OFS_END, 32'd500);
      u_host.wr(OFS_LOOP, 32'd999999);
      u_host.wr(OFS_LOOP, 32'd1000000);
      chk(OFS_LOOP, 32'd999999);
      u_host.wr(OFS_LIST, (32'd16 << LIST_POS_LSB) | 32'd16);
      u_host.wr(OFS_LIST, (32'd1 << LIST_POS_LSB) | 32'd17);
      chk(8'h7c, 32'd16);
      chk(8'h40, 32'h0);
      u_host.idle(3);
      // a write while the clock enable is low must leave no trace
      ce_i <= 1'b0;
      u_host.wr(OFS_END, 32'd7);
      u_host.idle(2);
      ce_i <= 1'b1;
      chk(OFS_END, 32'd500);
      u_host.idle(3);
      $display("test settings done");
      print_verdict();
   end
endmodule : osp_sequencer_test
bind osp_sequencer osp_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .req_i(req_i),
   .rdata_o(rdata_o), .setpoint_o(setpoint_o), .out_on_o(out_on_o));
`default_nettype wire
